// *** core/xbp_cfg.svh ***
// Purpose: constants of the external bus port
// Assumes: included by the package and the port design file
// Notes: fixed widths and levels, no tuning needed
`ifndef XBP_CFG_SVH
`define XBP_CFG_SVH

`define XBP_DEPTH 16
`define XBP_CNT_W 5
`define XBP_ADDR_W 28
`define XBP_ADDR_MSB 27
`define XBP_WAIT_W 8
`define XBP_DIV_W 16
`define XBP_REF_W 11
`define XBP_WAIT_RST 2'h0
`define XBP_TX_LVL_EMPTY 5'h00
`define XBP_TX_LVL_QUARTER 5'h04
`define XBP_TX_LVL_HALF 5'h08
`define XBP_TX_LVL_3QUARTER 5'h0C
`define XBP_RX_LVL_EIGHTH 5'h02
`define XBP_RX_LVL_QUARTER 5'h04
`define XBP_RX_LVL_HALF 5'h08
`define XBP_RX_LVL_3QUARTER 5'h0C
`define XBP_RX_LVL_7EIGHTH 5'h0E
`define XBP_RX_LVL_FULL 5'h10
`define XBP_SDRAM_MB_MIN 7'h08
`define XBP_ERR_WTFULL 0
`define XBP_ERR_RSTALL 1
`define XBP_ERR_TIMEOUT 2
`define XBP_IRQ_TX 0
`define XBP_IRQ_RX 1
`define XBP_IRQ_ERR 2

`endif

// *** core/xbp_pkg.sv ***
// Purpose: types of the external bus port
// Assumes: xbp_cfg.svh gives widths
// Notes: carriers for configuration, requests and pins
`include "xbp_cfg.svh"
package xbp_pkg;
    typedef enum logic [2:0] {
        xbp_mode_general, xbp_mode_sdram, xbp_mode_byte_host_bus, xbp_mode_half_host_bus,
        xbp_mode_off
    } xbp_mode_t;
    typedef enum logic [1:0] {
        muxed_addr_data_submode, split_addr_data_submode, static_ram_submode, queue_submode
    } xbp_submode_t;
    typedef enum logic [1:0] {xbp_cs_single, xbp_cs_latch, xbp_cs_dual, xbp_cs_latch_dual}
        xbp_cs_cfg_t;
    typedef struct packed {
        xbp_submode_t submode;
        logic use_tx_queue_empty;
        logic use_rx_queue_full;
        logic write_strobe_high;
        logic read_strobe_high;
        logic [1:0] wr_wait;
        logic [1:0] rd_wait;
        logic lane_routing_enable;
        logic per_select_rate;
        xbp_cs_cfg_t cs_cfg;
    } xbp_hb8_cfg_t;
    typedef struct packed {
        logic [1:0] core_band;
        logic self_refresh_select;
        logic [1:0] size;
        logic [`XBP_REF_W-1:0] refresh;
    } xbp_sdram_cfg_t;
    typedef struct packed {
        logic write_full_err_enable;
        logic read_stall_err_enable;
        logic [1:0] tx_level;
        logic [2:0] rx_level;
    } xbp_fifo_cfg_t;
    typedef struct packed {
        logic write;
        logic [`XBP_ADDR_W-1:0] addr;
        logic [31:0] data;
    } xbp_req_t;
    typedef struct packed {
        logic [7:0] ad_out;
        logic ad_oe;
        logic [`XBP_ADDR_W-1:0] addr_out;
        logic ctrl_pin_a;
        logic ctrl_pin_b;
        logic ctrl_pin_c;
        logic wr_strobe;
        logic rd_strobe;
    } xbp_pins_t;
endpackage

// *** core/xbp_port.sv ***
// Purpose: external bus port, byte host bus engine, SDRAM settings, FIFOs, errors
// Assumes: one clock clk, synchronous active-low reset, clk_en freezes state
// Notes: configuration is plain ports; pins are registered
`timescale 1ns/1ns
`include "xbp_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Queue with registered flags
module xbp_fifo
    import xbp_pkg::*;
#(
    parameter int W = 32,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] count
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_ff [D];
    logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
    logic [AW:0] nxt_count;
    logic push, pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ptr_ff];
    // Next fill level
    assign nxt_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Storage
    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and flags
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else if (clk_en) begin
            if (push) wr_ptr_ff <= (wr_ptr_ff == AW'(D - 1)) ? '0 : wr_ptr_ff + 1'b1;
            if (pop) rd_ptr_ff <= (rd_ptr_ff == AW'(D - 1)) ? '0 : rd_ptr_ff + 1'b1;
            count <= nxt_count;
            in_ready <= nxt_count != (AW + 1)'(D);
            out_valid <= nxt_count != '0;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Port top
module xbp_port
    import xbp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire xbp_mode_t mode,
    input wire xbp_hb8_cfg_t hb8_cfg,
    input wire xbp_sdram_cfg_t sdram_cfg,
    input wire xbp_fifo_cfg_t fifo_cfg,
    input wire logic [31:0] divider,
    input wire logic [`XBP_WAIT_W-1:0] max_wait,
    input wire logic [2:0] int_en,
    input wire logic [2:0] err_clear,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [`XBP_ADDR_W-1:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic rd_valid,
    output logic rd_ready,
    input wire logic [`XBP_ADDR_W-1:0] rd_addr,
    output logic rxd_valid,
    input wire logic rxd_ready,
    output logic [31:0] rxd_data,
    input wire logic [7:0] ad_in,
    input wire logic tx_queue_empty_in,
    input wire logic rx_queue_full_in,
    output xbp_pins_t pins,
    output logic port_enable,
    output logic [2:0] irq_raw,
    output logic [2:0] irq_masked,
    output logic error_irq,
    output logic [2:0] err_flags,
    output logic [1:0] sdram_core_band,
    output logic sdram_self_refresh,
    output logic [6:0] sdram_span_mb,
    output logic sdram_refresh
);
    typedef enum logic [1:0] {st_idle, st_hold, st_addr, st_strobe} xbp_state_t;

    xbp_state_t st_ff;
    xbp_req_t cur_ff, tx_head;
    logic [1:0] wait_cnt_ff;
    logic [`XBP_WAIT_W-1:0] hold_cnt_ff;
    logic [16:0] div_cnt_ff, period;
    logic [15:0] sel_div;
    logic rd_pend_ff;
    logic [`XBP_ADDR_W-1:0] rd_addr_ff;
    logic [7:0] ad_meta_ff, ad_sync_ff;
    logic txe_meta_ff, txe_sync_ff, rxf_meta_ff, rxf_sync_ff;
    logic [2:0] err_ff, err_set, irq_nxt;
    logic [`XBP_REF_W-1:0] ref_cnt_ff;
    logic tick, active, hold, need_addr, timeout, take_wr, take_rd, rx_push;
    logic tx_in_ready, tx_valid, rx_in_ready;
    logic [1:0] lane;
    logic [31:0] rx_word;
    logic [`XBP_CNT_W-1:0] tx_cnt, rx_cnt, tx_thr, rx_thr;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ad_meta_ff <= 8'h00;
            ad_sync_ff <= 8'h00;
            {txe_meta_ff, txe_sync_ff, rxf_meta_ff, rxf_sync_ff} <= 4'h0;
        end else if (clk_en) begin
            ad_meta_ff <= ad_in;
            ad_sync_ff <= ad_meta_ff;
            txe_meta_ff <= tx_queue_empty_in;
            txe_sync_ff <= txe_meta_ff;
            rxf_meta_ff <= rx_queue_full_in;
            rxf_sync_ff <= rxf_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write transaction queue and read data queue
    assign wr_ready = tx_in_ready;
    assign take_wr = tick && st_ff == st_idle && active && tx_valid;
    assign take_rd = tick && st_ff == st_idle && active && !tx_valid && rd_pend_ff
        && rx_in_ready;

    xbp_fifo #(.W($bits(xbp_req_t)), .D(`XBP_DEPTH)) tx_q (
        .clk(clk), .rst_b(rst_b), .clk_en(clk_en),
        .in_valid(wr_valid), .in_ready(tx_in_ready), .in_data({1'b1, wr_addr, wr_data}),
        .out_valid(tx_valid), .out_ready(take_wr), .out_data(tx_head), .count(tx_cnt)
    );

    xbp_fifo #(.W(32), .D(`XBP_DEPTH)) rx_q (
        .clk(clk), .rst_b(rst_b), .clk_en(clk_en),
        .in_valid(rx_push), .in_ready(rx_in_ready), .in_data(rx_word),
        .out_valid(rxd_valid), .out_ready(rxd_ready), .out_data(rxd_data), .count(rx_cnt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interface clock tick
    // per select divider
    assign sel_div = (hb8_cfg.per_select_rate && cur_ff.addr[`XBP_ADDR_MSB])
        ? divider[31:16] : divider[15:0];
    assign period = (sel_div == 16'h0000) ? 17'h00001
        : {1'b0, 1'b0, sel_div[15:1]} + 17'h00001 << 1;
    assign tick = div_cnt_ff >= period - 17'h00001;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_cnt_ff <= 17'h00000;
        end else if (clk_en) begin
            div_cnt_ff <= tick ? 17'h00000 : div_cnt_ff + 17'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transaction engine decode
    // byte bus only when selected
    assign active = mode == xbp_mode_byte_host_bus;
    assign hold = hb8_cfg.submode == queue_submode && (cur_ff.write
        ? hb8_cfg.use_rx_queue_full && rxf_sync_ff
        : hb8_cfg.use_tx_queue_empty && txe_sync_ff);
    assign need_addr = hb8_cfg.submode == muxed_addr_data_submode
        || hb8_cfg.cs_cfg == xbp_cs_latch || hb8_cfg.cs_cfg == xbp_cs_latch_dual;
    assign timeout = tick && st_ff == st_hold && hold && max_wait != '0
        && hold_cnt_ff + 1'b1 >= max_wait;
    assign lane = hb8_cfg.lane_routing_enable ? cur_ff.addr[1:0] : 2'h0;
    assign rx_push = tick && st_ff == st_strobe && !cur_ff.write && wait_cnt_ff == 2'h0;

    always_comb begin
        rx_word = 32'h00000000;
        rx_word[lane*8 +: 8] = ad_sync_ff;
    end

    // Pending read request
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_pend_ff <= 1'b0;
            rd_addr_ff <= '0;
            rd_ready <= 1'b0;
        end else if (clk_en) begin
            if (rd_valid && rd_ready) begin
                rd_pend_ff <= 1'b1;
                rd_addr_ff <= rd_addr;
            end else if (take_rd) begin
                rd_pend_ff <= 1'b0;
            end
            rd_ready <= !(rd_pend_ff || (rd_valid && rd_ready)) || take_rd;
        end
    end

    // Transaction state machine
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_ff <= st_idle;
            cur_ff <= '0;
            wait_cnt_ff <= `XBP_WAIT_RST;
            hold_cnt_ff <= '0;
        end else if (clk_en && tick) begin
            case (st_ff)
                st_idle: begin
                    hold_cnt_ff <= '0;
                    if (take_wr) begin
                        cur_ff <= tx_head;
                        st_ff <= st_hold;
                    end else if (take_rd) begin
                        cur_ff <= {1'b0, rd_addr_ff, 32'h00000000};
                        st_ff <= st_hold;
                    end
                end
                st_hold: begin
                    wait_cnt_ff <= cur_ff.write ? hb8_cfg.wr_wait : hb8_cfg.rd_wait;
                    if (timeout) begin
                        st_ff <= st_idle;
                    end else if (!hold) begin
                        st_ff <= need_addr ? st_addr : st_strobe;
                    end else begin
                        hold_cnt_ff <= hold_cnt_ff + 1'b1;
                    end
                end
                st_addr: st_ff <= st_strobe;
                st_strobe: begin
                    if (wait_cnt_ff == 2'h0) st_ff <= st_idle;
                    else wait_cnt_ff <= wait_cnt_ff - 2'h1;
                end
                default: st_ff <= st_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered pins
    always_ff @(posedge clk) begin
        logic strobe, latch, sel1;
        strobe = st_ff == st_strobe;
        latch = st_ff == st_addr;
        sel1 = cur_ff.addr[`XBP_ADDR_MSB];
        if (!rst_b) begin
            pins <= '0;
        end else if (clk_en) begin
            pins.addr_out <= cur_ff.addr;
            pins.ad_oe <= latch || (strobe && cur_ff.write);
            pins.ad_out <= latch ? cur_ff.addr[7:0] : cur_ff.data[lane*8 +: 8];
            pins.wr_strobe <= (strobe && cur_ff.write) == hb8_cfg.write_strobe_high;
            pins.rd_strobe <= (strobe && !cur_ff.write) == hb8_cfg.read_strobe_high;
            case (hb8_cfg.cs_cfg)
                xbp_cs_single: {pins.ctrl_pin_a, pins.ctrl_pin_b, pins.ctrl_pin_c}
                    <= {!(strobe || latch), 2'h3};
                xbp_cs_latch: {pins.ctrl_pin_a, pins.ctrl_pin_b, pins.ctrl_pin_c}
                    <= {latch, 2'h3};
                xbp_cs_dual: {pins.ctrl_pin_a, pins.ctrl_pin_b, pins.ctrl_pin_c}
                    <= {!(strobe && !sel1), !(strobe && sel1), 1'b1};
                default: {pins.ctrl_pin_a, pins.ctrl_pin_b, pins.ctrl_pin_c}
                    <= {latch, !(strobe && !sel1), !(strobe && sel1)};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error flags, set wins over clear
    // error causes
    assign err_set[`XBP_ERR_WTFULL] = wr_valid && !tx_in_ready;
    assign err_set[`XBP_ERR_RSTALL] = rd_valid && rd_ready
        && (tx_valid || (st_ff != st_idle && cur_ff.write));
    assign err_set[`XBP_ERR_TIMEOUT] = timeout;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            err_ff <= 3'h0;
        end else if (clk_en) begin
            err_ff <= (err_ff & ~err_clear) | err_set;
        end
    end
    assign err_flags = err_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Trigger levels and interrupt status
    // transmit level
    always_comb begin
        case (fifo_cfg.tx_level)
            2'h0: tx_thr = `XBP_TX_LVL_EMPTY;
            2'h1: tx_thr = `XBP_TX_LVL_QUARTER;
            2'h2: tx_thr = `XBP_TX_LVL_HALF;
            default: tx_thr = `XBP_TX_LVL_3QUARTER;
        endcase
    end

    always_comb begin
        case (fifo_cfg.rx_level)
            3'h0: rx_thr = `XBP_RX_LVL_EIGHTH;
            3'h1: rx_thr = `XBP_RX_LVL_QUARTER;
            3'h2: rx_thr = `XBP_RX_LVL_HALF;
            3'h3: rx_thr = `XBP_RX_LVL_3QUARTER;
            3'h4: rx_thr = `XBP_RX_LVL_7EIGHTH;
            default: rx_thr = `XBP_RX_LVL_FULL;
        endcase
    end

    assign irq_nxt[`XBP_IRQ_TX] = tx_cnt <= tx_thr;
    assign irq_nxt[`XBP_IRQ_RX] = rx_cnt >= rx_thr;
    assign irq_nxt[`XBP_IRQ_ERR] = err_ff[`XBP_ERR_TIMEOUT]
        || (err_ff[`XBP_ERR_WTFULL] && fifo_cfg.write_full_err_enable)
        || (err_ff[`XBP_ERR_RSTALL] && fifo_cfg.read_stall_err_enable);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_raw <= 3'h0;
            irq_masked <= 3'h0;
            error_irq <= 1'b0;
        end else if (clk_en) begin
            irq_raw <= irq_nxt;
            irq_masked <= irq_nxt & int_en;
            error_irq <= irq_nxt[`XBP_IRQ_ERR] && int_en[`XBP_IRQ_ERR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode and SDRAM settings
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            port_enable <= 1'b0;
            sdram_core_band <= 2'h0;
            sdram_self_refresh <= 1'b0;
            sdram_span_mb <= `XBP_SDRAM_MB_MIN;
        end else if (clk_en) begin
            port_enable <= mode != xbp_mode_off;
            sdram_core_band <= sdram_cfg.core_band;
            sdram_self_refresh <= mode == xbp_mode_sdram && sdram_cfg.self_refresh_select;
            sdram_span_mb <= `XBP_SDRAM_MB_MIN << sdram_cfg.size;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ref_cnt_ff <= '0;
            sdram_refresh <= 1'b0;
        end else if (clk_en) begin
            if (mode != xbp_mode_sdram || sdram_cfg.self_refresh_select
                    || sdram_cfg.refresh == '0) begin
                ref_cnt_ff <= '0;
                sdram_refresh <= 1'b0;
            end else begin
                sdram_refresh <= ref_cnt_ff + 1'b1 >= sdram_cfg.refresh;
                ref_cnt_ff <= (ref_cnt_ff + 1'b1 >= sdram_cfg.refresh) ? '0
                    : ref_cnt_ff + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    port_enable_a: assert property (clk_en && rst_b |=> port_enable == ($past(mode) != xbp_mode_off))
        else $error("port enable does not follow mode");
    addr_phase_a: assert property (st_ff == st_addr |-> need_addr)
        else $error("address phase in wrong submode");
    wr_polarity_a: assert property (clk_en && st_ff == st_strobe && cur_ff.write
        |=> pins.wr_strobe == $past(hb8_cfg.write_strobe_high))
        else $error("write strobe polarity wrong");
    rd_polarity_a: assert property (clk_en && st_ff == st_strobe && !cur_ff.write
        |=> pins.rd_strobe == $past(hb8_cfg.read_strobe_high))
        else $error("read strobe polarity wrong");
    wr_wait_a: assert property (clk_en && tick && st_ff == st_hold && cur_ff.write
        |=> wait_cnt_ff == $past(hb8_cfg.wr_wait))
        else $error("write wait states not loaded");
    rd_wait_a: assert property (clk_en && tick && st_ff == st_hold && !cur_ff.write
        |=> wait_cnt_ff == $past(hb8_cfg.rd_wait))
        else $error("read wait states not loaded");
    lane_low_a: assert property (rx_push && !hb8_cfg.lane_routing_enable
        |-> rx_word[31:8] == 24'h000000)
        else $error("byte left low lane");
    low_div_a: assert property (!hb8_cfg.per_select_rate |-> sel_div == divider[15:0])
        else $error("lower divider not used");
    tick_period_a: assert property (clk_en && !tick
        |=> div_cnt_ff == $past(div_cnt_ff) + 17'h00001)
        else $error("interface clock count skipped");
    hold_limit_a: assert property (clk_en && timeout
        |=> err_ff[`XBP_ERR_TIMEOUT] && st_ff == st_idle)
        else $error("timeout not flagged");
    set_wins_a: assert property (clk_en && err_set[`XBP_ERR_WTFULL]
        |=> err_ff[`XBP_ERR_WTFULL])
        else $error("write full flag lost");
    err_sticky_a: assert property (clk_en && err_ff[`XBP_ERR_RSTALL]
        && !err_clear[`XBP_ERR_RSTALL] |=> err_ff[`XBP_ERR_RSTALL])
        else $error("read stall flag dropped");
    irq_mask_a: assert property (clk_en |=> irq_masked == (irq_raw & $past(int_en)))
        else $error("masked status wrong");

    write_done_c: cover property (st_ff == st_strobe && cur_ff.write ##1 st_ff == st_idle);
    read_done_c: cover property (rx_push);
    timeout_c: cover property (timeout);
endmodule

// *** verif/tb_top.sv ***
// Purpose: self-checking bench of the external bus port
// Assumes: xbp_dev stands on the pins
// Notes: one task per scenario, every wait bounded
`timescale 1ns/1ns

////////////////////////////////////////
module tb_top
    import xbp_pkg::*;
;
    logic clk, rst_b, clk_en, wr_valid, wr_ready, rd_valid, rd_ready, rxd_valid, rxd_ready;
    logic txe, rxf, port_enable, error_irq, self_ref, refresh;
    xbp_mode_t mode;
    xbp_hb8_cfg_t hb;
    xbp_sdram_cfg_t sd;
    xbp_fifo_cfg_t ff;
    xbp_pins_t pins;
    logic [31:0] divider, wr_data, rxd_data;
    logic [27:0] wr_addr, rd_addr;
    logic [7:0] max_wait, ad_in, rd_byte, got;
    logic [2:0] int_en, err_clear, irq_raw, irq_masked, err_flags;
    logic [1:0] band;
    logic [6:0] span;
    int num_errors = 0;
    int n_checks = 0;
    int i, cnt;

    xbp_port u_xbp_port(.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .mode(mode), .hb8_cfg(hb),
        .sdram_cfg(sd), .fifo_cfg(ff), .divider(divider), .max_wait(max_wait), .int_en(int_en),
        .err_clear(err_clear), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_addr(rd_addr),
        .rxd_valid(rxd_valid), .rxd_ready(rxd_ready), .rxd_data(rxd_data), .ad_in(ad_in),
        .tx_queue_empty_in(txe), .rx_queue_full_in(rxf), .pins(pins), .port_enable(port_enable),
        .irq_raw(irq_raw), .irq_masked(irq_masked), .error_irq(error_irq), .err_flags(err_flags),
        .sdram_core_band(band), .sdram_self_refresh(self_ref), .sdram_span_mb(span),
        .sdram_refresh(refresh));
    xbp_dev u_xbp_dev(.clk(clk), .pins(pins), .wr_hi(hb.write_strobe_high),
        .rd_hi(hb.read_strobe_high), .rd_byte(rd_byte), .ad_in(ad_in), .got(got));

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Compare and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A spent wait bound ends the run
    task automatic bound(input int k);
        if (k >= 500) begin
            num_errors++;
            results();
        end
    endtask

    // Write request held until taken
    task automatic wr(input logic [27:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        i = 0;
        do @(posedge clk); while (wr_ready !== 1'b1 && ++i < 500);
        wr_valid <= 1'b0;
        bound(i);
    endtask

    // strobe level and byte lane per setting
    task automatic s_write();
        int p;
        for (p = 0; p < 2; p++) begin
            @(posedge clk);
            hb.write_strobe_high <= p[0];
            hb.lane_routing_enable <= p[0];
            repeat (3) @(posedge clk);
            chk(pins.wr_strobe, !p[0]);
            chk(pins.ctrl_pin_a, 1'b1);
            wr(28'h0000002, 32'hA1B2C3D4);
            for (cnt = 0; cnt < 200 && got !== (p ? 8'hB2 : 8'hD4); cnt++) @(posedge clk);
            chk(got, p ? 8'hB2 : 8'hD4);
        end
    endtask

    // slow read with waits lands in lane one
    task automatic s_read();
        @(posedge clk);
        hb.read_strobe_high <= 1'b1;
        hb.rd_wait <= 2'h3;
        divider <= 32'h00000002;
        rd_byte <= 8'h5A;
        repeat (3) @(posedge clk);
        chk(pins.rd_strobe, 1'b0);
        rd_valid <= 1'b1;
        rd_addr <= 28'h0000001;
        i = 0;
        do @(posedge clk); while (rd_ready !== 1'b1 && ++i < 500);
        rd_valid <= 1'b0;
        cnt = 0;
        do begin
            @(posedge clk);
            cnt += (pins.rd_strobe === 1'b1);
        end while (rxd_valid !== 1'b1 && ++i < 500);
        bound(i);
        chk(rxd_data, 32'h00005A00);
        chk(cnt, 16);
    endtask

    // held queue fills, refused write, clear
    task automatic s_full();
        int k;
        @(posedge clk);
        hb.submode <= queue_submode;
        hb.use_rx_queue_full <= 1'b1;
        rxf <= 1'b1;
        divider <= 32'h0;
        repeat (4) @(posedge clk);
        for (k = 0; k < 17; k++) wr(28'h0, 32'(k));
        repeat (3) @(posedge clk);
        chk(wr_ready, 1'b0);
        wr_valid <= 1'b1;
        @(posedge clk);
        wr_valid <= 1'b0;
        repeat (3) @(posedge clk);
        chk(err_flags, 3'h1);
        chk(error_irq, 1'b1);
        err_clear <= 3'h1;
        @(posedge clk);
        err_clear <= 3'h0;
        repeat (3) @(posedge clk);
        chk(err_flags, 3'h0);
        rxf <= 1'b0;
        i = 0;
        do @(posedge clk); while (irq_raw[0] !== 1'b1 && ++i < 500);
        bound(i);
    endtask

    // hold-off beyond max wait flags timeout
    task automatic s_tmo();
        @(posedge clk);
        max_wait <= 8'h03;
        rxf <= 1'b1;
        wr(28'h0, 32'h0);
        i = 0;
        do @(posedge clk); while (err_flags[2] !== 1'b1 && ++i < 40);
        chk(err_flags, 3'h4);
        repeat (2) @(posedge clk);
        chk(error_irq, 1'b1);
        rxf <= 1'b0;
    endtask

    task automatic s_sdram();
        int s;
        @(posedge clk);
        mode <= xbp_mode_sdram;
        sd.refresh <= 11'h005;
        sd.core_band <= 2'h2;
        for (s = 0; s < 4; s++) begin
            sd.size <= s[1:0];
            sd.self_refresh_select <= !s[0];
            repeat (3) @(posedge clk);
            chk(span, 7'h08 << s);
            chk(self_ref, !s[0]);
        end
        chk(band, 2'h2);
        i = 0;
        do @(posedge clk); while (refresh !== 1'b1 && ++i < 500);
        bound(i);
        i = 0;
        do @(posedge clk); while (refresh !== 1'b1 && ++i < 500);
        chk(32'(i + 1), 32'h5);
        mode <= xbp_mode_off;
        repeat (3) @(posedge clk);
        chk(port_enable, 1'b0);
    endtask

    // Main sequence
    initial begin
        {rst_b, wr_valid, rd_valid, txe, rxf, err_clear, divider, max_wait} = '0;
        {wr_addr, wr_data, rd_addr, rd_byte} = '0;
        {clk_en, rxd_ready} = 2'h3;
        int_en = 3'h7;
        mode = xbp_mode_byte_host_bus;
        hb = '0;
        hb.submode = static_ram_submode;
        sd = '0;
        ff = '0;
        ff.write_full_err_enable = 1'b1;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk(port_enable, 1'b1);
        chk(irq_raw, 3'h1);
        int_en <= 3'h6;
        repeat (3) @(posedge clk);
        chk(irq_masked, 3'h0);
        int_en <= 3'h7;
        s_write();
        s_read();
        s_full();
        s_tmo();
        s_sdram();
        results();
    end
endmodule

// *** verif/xbp_dev.sv ***
// Purpose: byte device standing on the port pins
// Assumes: strobe levels follow the bench settings
// Notes: bus data is valid only while the read strobe is active
`timescale 1ns/1ns

////////////////////////////////////////
module xbp_dev
    import xbp_pkg::*;
(
    input wire logic clk,
    input wire xbp_pins_t pins,
    input wire logic wr_hi,
    input wire logic rd_hi,
    input wire logic [7:0] rd_byte,
    output logic [7:0] ad_in,
    output logic [7:0] got
);
    initial ad_in = 8'h00;
    always @(posedge clk) begin
        if (pins.wr_strobe === wr_hi && pins.ad_oe === 1'b1) begin
            got <= pins.ad_out;
        end
    end
    // answer on active read strobe, else toggle
    always @(posedge clk) begin
        ad_in <= (pins.rd_strobe === rd_hi) ? rd_byte : ~ad_in;
    end
endmodule
